// file: rtl/epd_top.v
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "epd_regs.vh"

module epd_top #(
  parameter Z_WIDTH_CYC = (`EPD_ZW_NS + `EPD_CLK_NS - 1) / `EPD_CLK_NS
) (
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // axi4-lite write address
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // encoder steps at full encoder resolution
  input wire enc_step,
  input wire enc_ccw,
  // feedback pulse outputs
  output reg feedback_phase_a_out,
  output reg feedback_phase_b_out,
  output reg feedback_index_out,
  output reg home_index_out
);

  // software copies
  reg [3:0] ctrl_reg;
  reg [18:0] output_pulses_per_rev_reg;
  reg [22:0] output_divider_numerator_reg;
  reg [22:0] output_divider_denominator_reg;
  reg [19:0] index_position_offset_reg;
  reg index_seen_reg;
  // active settings, frozen once taken
  reg latched_reg;
  reg ppr_mode_reg;
  reg lead_reg;
  reg enc18_reg;
  reg [23:0] inc_reg;
  reg [23:0] mod_reg;
  reg [19:0] ofs_reg;
  // pulse engine state
  reg [19:0] pos_reg;
  reg [23:0] acc_reg;
  reg [1:0] quad_reg;
  reg z_arm_reg;
  reg [12:0] z_cnt_reg;
  wire [31:0] z_load = Z_WIDTH_CYC - 1;
  // axi write side holding
  reg aw_have_reg;
  reg w_have_reg;
  reg [5:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  // clamped settings for the latch
  reg [18:0] ppr_c;
  reg [22:0] num_c;
  reg [22:0] den_c;
  reg [19:0] ofs_c;
  reg [19:0] res_top;
  reg [23:0] inc_c;
  reg [23:0] mod_c;
  reg ppr_nz;

  always @* begin
    ppr_nz = output_pulses_per_rev_reg != `EPD_RST_PPR;
    if (output_pulses_per_rev_reg < `EPD_PPR_MIN)
      ppr_c = `EPD_PPR_MIN;
    else if (ctrl_reg[`EPD_CTRL_ENC18] &&
             output_pulses_per_rev_reg > `EPD_PPR_MAX18)
      ppr_c = `EPD_PPR_MAX18;
    else if (output_pulses_per_rev_reg > `EPD_PPR_MAX20)
      ppr_c = `EPD_PPR_MAX20;
    else
      ppr_c = output_pulses_per_rev_reg;
    num_c = output_divider_numerator_reg;
    if (num_c == 23'h000000)
      num_c = `EPD_RST_NUM;
    else if (num_c > `EPD_DIV_MAX)
      num_c = `EPD_DIV_MAX;
    den_c = output_divider_denominator_reg;
    if (den_c == 23'h000000)
      den_c = `EPD_RST_NUM;
    else if (den_c > `EPD_DIV_MAX)
      den_c = `EPD_DIV_MAX;
    res_top = ctrl_reg[`EPD_CTRL_ENC18] ? `EPD_RES18 : `EPD_RES20;
    ofs_c = index_position_offset_reg > res_top ? res_top :
      index_position_offset_reg;
    if (ppr_nz) begin
      // pulses counted against encoder count over four
      inc_c = {5'h00, ppr_c};
      mod_c = ctrl_reg[`EPD_CTRL_ENC18] ? `EPD_BASE18 :
        `EPD_BASE20;
    end else begin
      // divider never multiplies
      inc_c = {1'b0, (num_c > den_c) ? den_c : num_c};
      mod_c = {1'b0, den_c};
    end
  end

  // encoder step, one output edge at most per step since inc <= mod
  reg [19:0] act_top;
  reg [19:0] pos_next;
  reg [23:0] acc_next;
  reg [24:0] sum;
  reg edge_fwd;
  reg edge_back;
  reg [1:0] quad_next;
  reg a_next;
  reg b_next;
  reg idx_hit;
  reg [19:0] pos_adj;
  always @* begin
    act_top = enc18_reg ? `EPD_RES18 : `EPD_RES20;
    pos_next = pos_reg;
    acc_next = acc_reg;
    sum = {1'b0, acc_reg} + {1'b0, inc_reg};
    edge_fwd = 1'b0;
    edge_back = 1'b0;
    if (latched_reg && enc_step) begin
      if (enc_ccw) begin
        pos_next = (pos_reg == act_top) ? 20'h00000 : pos_reg + 20'h00001;
        if (sum >= {1'b0, mod_reg}) begin
          acc_next = sum[23:0] - mod_reg;
          edge_fwd = 1'b1;
        end else begin
          acc_next = sum[23:0];
        end
      end else begin
        pos_next = (pos_reg == 20'h00000) ? act_top : pos_reg - 20'h00001;
        if (acc_reg >= inc_reg) begin
          acc_next = acc_reg - inc_reg;
        end else begin
          acc_next = acc_reg + mod_reg - inc_reg;
          edge_back = 1'b1;
        end
      end
    end
    // each edge is a quarter of an output period
    quad_next = quad_reg;
    if (edge_fwd)
      quad_next = quad_reg + 2'h1;
    else if (edge_back)
      quad_next = quad_reg - 2'h1;
    // gray order 00,01,11,10 puts the second bit first on ccw
    if (lead_reg) begin
      a_next = quad_next[1] ^ quad_next[0];
      b_next = quad_next[1];
    end else begin
      a_next = quad_next[1];
      b_next = quad_next[1] ^ quad_next[0];
    end
    // offset shifts the index toward ccw, direction setting unused
    idx_hit = latched_reg && enc_step &&
      (pos_next == ofs_reg);
    pos_adj = (pos_reg >= ofs_reg) ? pos_reg - ofs_reg :
      pos_reg + act_top - ofs_reg + 20'h00001;
  end

  // settings latch and pulse engine
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      latched_reg <= 1'b0;
      ppr_mode_reg <= 1'b0;
      lead_reg <= 1'b0;
      enc18_reg <= 1'b0;
      inc_reg <= 24'h000000;
      mod_reg <= 24'h000001;
      ofs_reg <= 20'h00000;
      pos_reg <= 20'h00000;
      acc_reg <= 24'h000000;
      quad_reg <= 2'h0;
      z_arm_reg <= 1'b0;
      z_cnt_reg <= 13'h0000;
      feedback_phase_a_out <= 1'b0;
      feedback_phase_b_out <= 1'b0;
      feedback_index_out <= 1'b0;
      home_index_out <= 1'b0;
    end else begin
      // only the first apply counts until the next reset
      if (!latched_reg && ctrl_reg[`EPD_CTRL_APPLY]) begin
        latched_reg <= 1'b1;
        ppr_mode_reg <= ppr_nz;
        lead_reg <= ctrl_reg[`EPD_CTRL_LEAD];
        enc18_reg <= ctrl_reg[`EPD_CTRL_ENC18];
        inc_reg <= inc_c;
        mod_reg <= mod_c;
        ofs_reg <= ofs_c;
      end
      pos_reg <= pos_next;
      acc_reg <= acc_next;
      quad_reg <= quad_next;
      feedback_phase_a_out <= a_next;
      feedback_phase_b_out <= b_next;
      home_index_out <= idx_hit;
      if (ppr_mode_reg) begin
        // index rides the next A high phase
        if (idx_hit)
          z_arm_reg <= 1'b1;
        if (a_next && !feedback_phase_a_out && (z_arm_reg || idx_hit)) begin
          feedback_index_out <= 1'b1;
          z_arm_reg <= 1'b0;
        end else if (!a_next && feedback_phase_a_out) begin
          feedback_index_out <= 1'b0;
        end
      end else begin
        // fixed width, unrelated to A and B
        if (idx_hit) begin
          feedback_index_out <= 1'b1;
          z_cnt_reg <= z_load[12:0];
        end else if (z_cnt_reg != 13'h0000) begin
          z_cnt_reg <= z_cnt_reg - 13'h0001;
        end else begin
          feedback_index_out <= 1'b0;
        end
      end
    end
  end

  // axi write path, address and data in either order
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire [5:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr_reg;
  wire [31:0] wr_data = w_take ? s_axi_wdata : w_data_reg;
  wire [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb_reg;
  wire wr_go = (aw_have_reg || aw_take) && (w_have_reg || w_take) &&
    !s_axi_bvalid;
  wire wr_hit = (wr_addr == `EPD_OFS_CTRL) || (wr_addr == `EPD_OFS_PPR) ||
    (wr_addr == `EPD_OFS_NUM) || (wr_addr == `EPD_OFS_DEN) ||
    (wr_addr == `EPD_OFS_ZOFS) || (wr_addr == `EPD_OFS_STAT);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  wire [31:0] ctrl_m = merge({28'h0000000, ctrl_reg}, wr_data, wr_strb);
  wire [31:0] ppr_m = merge({13'h0000, output_pulses_per_rev_reg},
    wr_data, wr_strb);
  wire [31:0] num_m = merge({9'h000, output_divider_numerator_reg},
    wr_data, wr_strb);
  wire [31:0] den_m = merge({9'h000, output_divider_denominator_reg},
    wr_data, wr_strb);
  wire [31:0] zofs_m = merge({12'h000, index_position_offset_reg},
    wr_data, wr_strb);
  wire stat_clr = wr_go && (wr_addr == `EPD_OFS_STAT) && wr_strb[0] &&
    wr_data[`EPD_STAT_INDEX];

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EPD_RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 6'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      ctrl_reg <= 4'h0;
      output_pulses_per_rev_reg <= `EPD_RST_PPR;
      output_divider_numerator_reg <= `EPD_RST_NUM;
      output_divider_denominator_reg <= `EPD_RST_DEN;
      index_position_offset_reg <= `EPD_RST_ZOFS;
      index_seen_reg <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `EPD_RESP_OKAY : `EPD_RESP_SLVERR;
        case (wr_addr)
          `EPD_OFS_CTRL: ctrl_reg <= ctrl_m[3:0];
          `EPD_OFS_PPR: output_pulses_per_rev_reg <= ppr_m[18:0];
          `EPD_OFS_NUM: output_divider_numerator_reg <= num_m[22:0];
          `EPD_OFS_DEN: output_divider_denominator_reg <= den_m[22:0];
          `EPD_OFS_ZOFS: index_position_offset_reg <= zofs_m[19:0];
          default: ctrl_reg <= ctrl_reg;
        endcase
      end else begin
        if (aw_take)
          aw_have_reg <= 1'b1;
        if (w_take)
          w_have_reg <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      // a new index beats a clear in the same cycle
      if (idx_hit)
        index_seen_reg <= 1'b1;
      else if (stat_clr)
        index_seen_reg <= 1'b0;
    end
  end

  // axi read path, answer one cycle after the address
  reg [31:0] rd_mux;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `EPD_OFS_CTRL: rd_mux = {28'h0000000, ctrl_reg};
      `EPD_OFS_PPR: rd_mux = {13'h0000, output_pulses_per_rev_reg};
      `EPD_OFS_NUM: rd_mux = {9'h000, output_divider_numerator_reg};
      `EPD_OFS_DEN: rd_mux = {9'h000, output_divider_denominator_reg};
      `EPD_OFS_ZOFS: rd_mux = {12'h000, index_position_offset_reg};
      `EPD_OFS_STAT: rd_mux = {30'h00000000, index_seen_reg, latched_reg};
      `EPD_OFS_POS: rd_mux = {12'h000, pos_adj};
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `EPD_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `EPD_RESP_OKAY : `EPD_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // epd_top

// file: rtl/epd_regs.vh
`ifndef EPD_REGS_VH
`define EPD_REGS_VH

// register byte offsets
`define EPD_OFS_CTRL 6'h00
`define EPD_OFS_PPR 6'h04
`define EPD_OFS_NUM 6'h08
`define EPD_OFS_DEN 6'h0C
`define EPD_OFS_ZOFS 6'h10
`define EPD_OFS_STAT 6'h14
`define EPD_OFS_POS 6'h18

// control bits
`define EPD_CTRL_APPLY 0
`define EPD_CTRL_LEAD 1
`define EPD_CTRL_ENC18 2
`define EPD_CTRL_ROTDIR 3
// status bits
`define EPD_STAT_LATCHED 0
`define EPD_STAT_INDEX 1

// reset values
`define EPD_RST_PPR 19'h00000
`define EPD_RST_NUM 23'h000001
`define EPD_RST_DEN 23'h000010
`define EPD_RST_ZOFS 20'h00000

// limits
`define EPD_PPR_MIN 19'h00010
`define EPD_PPR_MAX20 19'h40000
`define EPD_PPR_MAX18 19'h10000
`define EPD_DIV_MAX 23'h400000
`define EPD_BASE20 24'h040000
`define EPD_BASE18 24'h010000
`define EPD_RES20 20'hFFFFF
`define EPD_RES18 20'h3FFFF

// index pulse width in divider mode
`define EPD_ZW_NS 125000
`define EPD_CLK_NS 20

`define EPD_RESP_OKAY 2'h0
`define EPD_RESP_SLVERR 2'h2

`endif

// file: tb/epd_sva.sv
`timescale 1ns/1ps
module epd_sva #(
  parameter Z_WIDTH_CYC = 6250
) (
  // clock, reset
  input wire mclk,
  input wire arst_n,
  // register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // encoder and feedback
  input wire enc_step,
  input wire feedback_phase_a_out,
  input wire feedback_phase_b_out,
  input wire feedback_index_out,
  input wire home_index_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // cycles the index has been high so far
  reg [15:0] zc_reg;
  always @(posedge mclk or negedge arst_n)
    if (!arst_n) zc_reg <= 16'h0000;
    else zc_reg <= feedback_index_out ? zc_reg + 16'h0001 : 16'h0000;
  a_quad_edge: assert property (
    !($changed(feedback_phase_a_out) && $changed(feedback_phase_b_out)))
    else $error("A and B changed together");
  a_step_cause: assert property (
    !$past(enc_step) |-> $stable({feedback_phase_a_out,
    feedback_phase_b_out})) else $error("A/B moved without a step");
  a_z_width: assert property (
    $fell(feedback_index_out) |-> $fell(feedback_phase_a_out) ||
    zc_reg == Z_WIDTH_CYC) else $error("index width wrong");
  a_home_once: assert property (
    home_index_out |=> !home_index_out) else $error("home pulse too long");
  a_home_step: assert property (
    home_index_out |-> $past(enc_step) || $past(enc_step, 2))
    else $error("home pulse without a step");
  a_wr_resp: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write response late");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rd_lat: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_ar_block: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  c_index: cover property ($rose(feedback_index_out));
  c_home: cover property (home_index_out);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule // epd_sva

bind epd_top epd_sva #(.Z_WIDTH_CYC(Z_WIDTH_CYC)) u_sva (
  .mclk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .enc_step,
  .feedback_phase_a_out, .feedback_phase_b_out, .feedback_index_out,
  .home_index_out);

// file: tb/epd_host_model.sv
`timescale 1ns/1ps
module epd_host_model (
  // clock, reset
  input wire mclk,
  input wire arst_n,
  // feedback lines, phase setting
  input wire a,
  input wire b,
  input wire z,
  input wire lead,
  // counts
  output logic [31:0] pos,
  output logic [31:0] zcnt
);
  // swap lines when A leads so one gray table serves both settings
  wire [1:0] s = lead ? {b, a} : {a, b};
  wire [1:0] g = {s[1], s[1] ^ s[0]};
  logic [1:0] pg;
  logic zq;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pg <= 2'h0;
      zq <= 1'b0;
      pos <= 32'h0;
      zcnt <= 32'h0;
    end else begin
      pg <= g;
      zq <= z;
      if (g == pg + 2'h1) pos <= pos + 32'h1;
      else if (g == pg - 2'h1) pos <= pos - 32'h1;
      if (z && !zq) zcnt <= zcnt + 32'h1;
    end
  end
endmodule // epd_host_model

// file: tb/tb.sv
`timescale 1ns/1ps
`include "epd_regs.vh"
module tb;
  logic mclk = 1'b0, arst_n = 1'b0, lead = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, enc_step = 1'b0, enc_ccw = 1'b0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, pos, zcnt, homes, cyc = 0;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, fa, fb, fz, home;
  int error_cnt = 0, checks = 0;
  always #10 mclk = ~mclk;
  epd_top #(.Z_WIDTH_CYC(8)) u_dut (.mclk(mclk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .enc_step(enc_step),
    .enc_ccw(enc_ccw), .feedback_phase_a_out(fa), .feedback_phase_b_out(fb),
    .feedback_index_out(fz), .home_index_out(home));
  epd_host_model u_host (.mclk(mclk), .arst_n(arst_n), .a(fa), .b(fb),
    .z(fz), .lead(lead), .pos(pos), .zcnt(zcnt));
  always @(posedge mclk or negedge arst_n)
    if (!arst_n) homes <= 32'h0;
    else homes <= homes + home;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up;
    end
  end
  task wrap_up;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input [5:0] a, input [31:0] d, input [1:0] er = `EPD_RESP_OKAY);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(bresp, er);
    @(posedge mclk);
  endtask
  task rd(input [5:0] a, input [31:0] ex, input [1:0] er = `EPD_RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, ex);
    chk(rresp, er);
    @(posedge mclk);
  endtask
  task steps(input int n, input bit ccw);
    repeat (n) begin
      enc_step <= 1'b1;
      enc_ccw <= ccw;
      @(posedge mclk);
    end
    enc_step <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task do_reset;
    arst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
  endtask
  // settings, then apply; only the first apply after reset counts
  task cfg(input [3:0] c, input [31:0] p, n, d, o);
    do_reset;
    lead <= c[1];
    wr(`EPD_OFS_PPR, p);
    wr(`EPD_OFS_NUM, n);
    wr(`EPD_OFS_DEN, d);
    wr(`EPD_OFS_ZOFS, o);
    wr(`EPD_OFS_CTRL, {28'h0, c});
    repeat (2) @(posedge mclk);
  endtask
  task t_regs;
    do_reset;
    rd(`EPD_OFS_NUM, 32'h1);
    rd(`EPD_OFS_DEN, 32'h10);
    rd(`EPD_OFS_PPR, 32'h0);
    wr(`EPD_OFS_NUM, 32'h400000);
    rd(`EPD_OFS_NUM, 32'h400000);
    wr(6'h1C, 32'h5, `EPD_RESP_SLVERR);
    rd(6'h1C, 32'h0, `EPD_RESP_SLVERR);
    $display("regs done");
  endtask
  task t_ppr20;
    cfg(4'h9, 32'h40000, 32'h1, 32'h10, 32'h5);
    steps(1, 1'b1);
    chk({fa, fb}, 32'h1);
    steps(39, 1'b1);
    chk(pos, 32'd40);
    chk(zcnt, 32'h1);
    chk(homes, 32'h1);
    rd(`EPD_OFS_STAT, 32'h3);
    wr(`EPD_OFS_STAT, 32'h2);
    rd(`EPD_OFS_STAT, 32'h1);
    rd(`EPD_OFS_POS, 32'd35);
    wr(`EPD_OFS_CTRL, 32'h3);
    wr(`EPD_OFS_PPR, 32'h10);
    steps(40, 1'b0);
    chk(pos, 32'h0);
    chk(homes, 32'h2);
    rd(`EPD_OFS_POS, 32'hFFFFB);
    $display("ppr20 done");
  endtask
  task t_ppr18;
    cfg(4'h7, 32'h20000, 32'h1, 32'h10, 32'h0);
    steps(1, 1'b1);
    chk({fa, fb}, 32'h2);
    steps(15, 1'b1);
    chk(pos, 32'd16);
    $display("ppr18 done");
  endtask
  task t_div;
    cfg(4'h1, 32'h0, 32'h1, 32'h2, 32'h3);
    steps(64, 1'b1);
    chk(pos, 32'd32);
    chk(zcnt, 32'h1);
    wr(`EPD_OFS_PPR, 32'h40000);
    steps(8, 1'b1);
    chk(pos, 32'd36);
    $display("div done");
  endtask
  task t_ratio1;
    cfg(4'h1, 32'h0, 32'h5, 32'h3, 32'h0);
    steps(20, 1'b1);
    chk(pos, 32'd20);
    $display("ratio1 done");
  endtask
  initial begin
    t_regs;
    t_ppr20;
    t_ppr18;
    t_div;
    t_ratio1;
    wrap_up;
  end
endmodule // tb
